// [hw/down_timer_pwm_buzzer.sv]
// Down timer with prescaler, pulse output and tone output behind APB
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tmr_defs.svh"
module down_timer_pwm_buzzer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  tmr_pkg::byte_t control_reg_one;
  tmr_pkg::byte_t control_reg_two;
  tmr_pkg::byte_t timer_count_value;
  tmr_pkg::byte_t reload_holding;
  tmr_pkg::byte_t pulse_duty_value;
  tmr_pkg::byte_t tone_control_reg;
  logic           underflow_flag;
  logic           underflow_irq_enable;
  logic           global_irq_enable;
  logic [1:0]     pin_config;
  logic           stopped;
  logic           pin_prev;
  logic [1:0]     inst_cnt;
  logic [7:0]     prescaler_count_value;
  logic           presc_pulse;
  logic           tone;
  logic           timer_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; single-cycle answer, no wait states
  wire access  = psel && penable;
  wire wr      = access && pwrite;
  wire hit_c1  = paddr == `OFF_CTRL_ONE;
  wire hit_c2  = paddr == `OFF_CTRL_TWO;
  wire hit_cnt = paddr == `OFF_COUNT;
  wire hit_dty = paddr == `OFF_DUTY;
  wire hit_ton = paddr == `OFF_TONE;
  wire hit_psc = paddr == `OFF_PRESC;
  wire hit_ifl = paddr == `OFF_IRQ_FLAG;
  wire hit_ien = paddr == `OFF_IRQ_ENABLE;
  wire hit_gie = paddr == `OFF_GLOBAL_IRQ;
  wire hit_cfg = paddr == `OFF_PIN_CONFIG;
  wire mapped  = hit_c1 | hit_c2 | hit_cnt | hit_dty | hit_ton | hit_psc |
                 hit_ifl | hit_ien | hit_gie | hit_cfg;
  wire wr_cnt  = wr && hit_cnt;

  // Field aliases
  wire run_enable      = control_reg_one[`C1_RUN];
  wire reload_select   = control_reg_one[`C1_RELOAD];
  wire one_shot_select = control_reg_one[`C1_ONE_SHOT];
  wire pulse_active_low = control_reg_one[`C1_ACTIVE_LOW];
  wire pulse_out_enable = control_reg_one[`C1_PULSE_EN];
  wire count_source_select = control_reg_two[`C2_SOURCE];
  wire count_edge_select   = control_reg_two[`C2_EDGE];
  wire prescaler_enable_n  = control_reg_two[`C2_PRESC_N];
  wire tone_enable    = tone_control_reg[`TONE_EN];
  wire [3:0] tone_freq_select = tone_control_reg[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Count source: instruction clock is pclk divided down
  wire inst_tick = inst_cnt == 2'(`INST_DIV - 1);
  wire ext_rise  = pin_in && !pin_prev;
  wire ext_fall  = !pin_in && pin_prev;
  wire ext_tick  = count_edge_select ? ext_fall : ext_rise;
  wire src_tick  = count_source_select ? ext_tick : inst_tick;
  wire run_tick  = src_tick && run_enable && !stopped;

  pow2_divider #(.WIDTH(8)) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (prescaler_enable_n || wr_cnt),
    .tick    (run_tick),
    .ratio   (control_reg_two[2:0]),
    .count   (prescaler_count_value),
    .pulse   (presc_pulse)
  );

  // Prescaler bypassed when enable_n is 1; its pulse lags one cycle
  wire count_tick = prescaler_enable_n ? run_tick : presc_pulse;
  wire underflow  = count_tick && timer_count_value == 8'h00;
  wire [7:0] next_count = !underflow ? timer_count_value - 8'h01 :
                          (one_shot_select ? 8'h00 :
                           (reload_select ? reload_holding : `COUNT_TOP));

  ////////////////////////////////////////////////////////////////////////
  // Instruction clock divider and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_cnt <= 2'h0;
      pin_prev <= 1'b0;
    end else begin
      inst_cnt <= inst_tick ? 2'h0 : inst_cnt + 2'h1;
      pin_prev <= pin_in;
    end
  end

  // Control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_one      <= `RESET_BYTE;
      control_reg_two      <= {4'h0, `RESET_PRESC_N, 3'h0};
      pulse_duty_value     <= `RESET_BYTE;
      tone_control_reg     <= `RESET_BYTE;
      underflow_irq_enable <= 1'b0;
      global_irq_enable    <= 1'b0;
      pin_config           <= 2'h0;
    end else if (wr) begin
      if (hit_c1)  control_reg_one      <= pwdata[7:0];
      if (hit_c2)  control_reg_two      <= {2'h0, pwdata[5:0]};
      if (hit_dty) pulse_duty_value     <= pwdata[7:0];
      if (hit_ton) tone_control_reg     <= {pwdata[7], 3'h0, pwdata[3:0]};
      if (hit_ien) underflow_irq_enable <= pwdata[`IRQ_UNDERFLOW];
      if (hit_gie) global_irq_enable    <= pwdata[0];
      if (hit_cfg) pin_config           <= pwdata[1:0];
    end
  end

  // Counter, reload holding and one-shot stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_value <= `RESET_BYTE;
      reload_holding    <= `RESET_BYTE;
      stopped           <= 1'b0;
      timer_pulse       <= 1'b0;
    end else begin
      timer_pulse <= underflow;
      if (wr_cnt) begin
        reload_holding    <= pwdata[7:0];
        timer_count_value <= pwdata[7:0];
        stopped           <= 1'b0;
      end else if (count_tick) begin
        timer_count_value <= next_count;
        if (underflow && one_shot_select)
          stopped <= 1'b1;
      end
      if (wr && hit_c1 && !pwdata[`C1_RUN])
        stopped <= 1'b0;
    end
  end

  // Sticky flag; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      underflow_flag <= 1'b0;
    else if (underflow)
      underflow_flag <= 1'b1;
    else if (wr && hit_ifl && !pwdata[`IRQ_UNDERFLOW])
      underflow_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Tone generator fed by prescaler or timer events
  tone_gen u_tone (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (tone_enable),
    .src_pulse (tone_freq_select[`TONE_SRC] ? timer_pulse : presc_pulse),
    .ratio     (tone_freq_select[2:0]),
    .tone      (tone)
  );

  // Pulse level: active on counts 1..duty, so duty N gives N counts a frame
  // and duty 0 is never active; the underflow count itself stays inactive
  wire pulse_active = (timer_count_value != 8'h00) &&
                      (timer_count_value <= pulse_duty_value);
  wire pulse_output = pulse_active ^ pulse_active_low;
  wire pulse_sel  = pulse_out_enable && pin_config[`CFG_PULSE];
  wire tone_sel   = tone_enable && pin_config[`CFG_TONE];
  // Pin stays input while it is the count source
  wire drive_pin  = (pulse_sel || tone_sel) && !count_source_select;

  // Read mux
  wire [31:0] rd_val =
      hit_c1  ? {24'h0, control_reg_one} :
      hit_c2  ? {24'h0, control_reg_two} :
      hit_cnt ? {24'h0, timer_count_value} :
      hit_dty ? {24'h0, pulse_duty_value} :
      hit_ton ? {24'h0, tone_control_reg} :
      hit_psc ? {24'h0, prescaler_count_value} :
      hit_ifl ? {28'h0, underflow_flag, 3'h0} :
      hit_ien ? {28'h0, underflow_irq_enable, 3'h0} :
      hit_gie ? {31'h0, global_irq_enable} :
      hit_cfg ? {30'h0, pin_config} : 32'h0;

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      irq     <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable)
        prdata <= rd_val;
      pin_out <= pulse_sel ? pulse_output : tone;
      pin_oe  <= drive_pin;
      irq     <= underflow_flag && underflow_irq_enable && global_irq_enable;
    end
  end
endmodule : down_timer_pwm_buzzer

// [hw/pow2_divider.sv]
// Power-of-two event divider with a readable count
`timescale 1ns/1ps
module pow2_divider #(
  parameter int WIDTH = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clear,
  input  wire logic                tick,
  input  wire tmr_pkg::ratio_t     ratio,
  output logic [WIDTH-1:0]         count,
  output logic                     pulse
);
  // Terminal value for ratio 2^(ratio+1)
  wire [WIDTH-1:0] last = WIDTH'((9'h002 << ratio) - 9'h001);
  wire             wrap = tick && (count >= last);

  // Counter wraps at the selected ratio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= wrap;
      if (clear)
        count <= '0;
      else if (wrap)
        count <= '0;
      else if (tick)
        count <= count + 1'b1;
    end
  end
endmodule : pow2_divider

// [hw/tmr_defs.svh]
// Offsets, field positions, reset values and timing counts of the down timer
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define OFF_CTRL_ONE     12'h000
`define OFF_CTRL_TWO     12'h004
`define OFF_COUNT        12'h008
`define OFF_DUTY         12'h00C
`define OFF_TONE         12'h010
`define OFF_PRESC        12'h014
`define OFF_IRQ_FLAG     12'h018
`define OFF_IRQ_ENABLE   12'h01C
`define OFF_GLOBAL_IRQ   12'h020
`define OFF_PIN_CONFIG   12'h024
`define C1_RUN           0
`define C1_RELOAD        1
`define C1_ONE_SHOT      2
`define C1_ACTIVE_LOW    6
`define C1_PULSE_EN      7
`define C2_SOURCE        5
`define C2_EDGE          4
`define C2_PRESC_N       3
`define TONE_EN          7
`define TONE_SRC         3
`define IRQ_UNDERFLOW    3
`define CFG_PULSE        0
`define CFG_TONE         1
`define RESET_BYTE       8'h00
`define RESET_PRESC_N    1'b1
`define COUNT_TOP        8'hFF
`define INST_DIV         4
`endif

// [hw/tmr_pkg.sv]
// Types shared by the down timer files
package tmr_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] ratio_t;
endpackage : tmr_pkg

// [hw/tone_gen.sv]
// Tone square wave: divided source toggles the output
`timescale 1ns/1ps
module tone_gen (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            enable,
  input  wire logic            src_pulse,
  input  wire tmr_pkg::ratio_t ratio,
  output logic                 tone
);
  logic       div_pulse;

  pow2_divider #(.WIDTH(8)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!enable),
    .tick    (src_pulse),
    .ratio   (ratio),
    .count   (),
    .pulse   (div_pulse)
  );

  // Toggle per divided event; idles low when off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tone <= 1'b0;
    else if (!enable)
      tone <= 1'b0;
    else if (div_pulse)
      tone <= !tone;
  end
endmodule : tone_gen

// [sim/down_timer_pwm_buzzer_bench.sv]
// Self-checking bench of the down timer
`timescale 1ns/1ps
`include "tmr_defs.svh"
`define CHK(g, e) cmp(g, e)
module down_timer_pwm_buzzer_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, v;
  logic        pready, pslverr, pin_lvl, pin_out, pin_oe, irq, e;
  int          err_total = 0, checks = 0, hi, oe_n;
  always #2 pclk = ~pclk;
  down_timer_pwm_buzzer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  ext_clk_src src (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_lvl));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      summarize();
    end
    v = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Skips one edge so registered pin outputs follow the last write
  task automatic watch(input int n);
    hi = 0; oe_n = 0;
    @(posedge pclk);
    repeat (n) begin
      @(negedge pclk);
      hi += pin_out; oe_n += pin_oe;
    end
  endtask : watch
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_count;
    apb(1, `OFF_CTRL_TWO, 32'h08); apb(1, `OFF_COUNT, 32'h05);
    repeat (20) @(posedge pclk);
    apb(0, `OFF_COUNT, 0); `CHK(v, 32'h05);
    apb(1, `OFF_CTRL_ONE, 32'h05); repeat (60) @(posedge pclk);
    apb(0, `OFF_COUNT, 0); `CHK(v, 32'h00);
    apb(0, `OFF_IRQ_FLAG, 0); `CHK(v, 32'h08);
    apb(1, `OFF_CTRL_ONE, 0); apb(1, `OFF_COUNT, 32'h02); apb(1, `OFF_CTRL_ONE, 32'h03);
    repeat (60) @(posedge pclk);
    apb(0, `OFF_COUNT, 0); `CHK(v <= 32'h02, 1);
    apb(1, `OFF_CTRL_ONE, 0); apb(1, `OFF_COUNT, 32'h02); apb(1, `OFF_CTRL_ONE, 32'h01);
    repeat (40) @(posedge pclk);
    apb(0, `OFF_COUNT, 0); `CHK(v > 32'h02, 1);
    apb(1, `OFF_CTRL_ONE, 0); apb(0, `OFF_IRQ_FLAG, 0); `CHK(v, 32'h08);
    $display("count test done");
  endtask : t_count
  task automatic t_irq;
    apb(1, `OFF_IRQ_ENABLE, 32'h08); apb(1, `OFF_GLOBAL_IRQ, 32'h01);
    repeat (3) @(posedge pclk); `CHK(irq, 1);
    apb(1, `OFF_GLOBAL_IRQ, 0); repeat (3) @(posedge pclk); `CHK(irq, 0);
    apb(1, `OFF_GLOBAL_IRQ, 32'h01); apb(1, `OFF_IRQ_FLAG, 0);
    apb(0, `OFF_IRQ_FLAG, 0); `CHK(v, 0); `CHK(irq, 0);
    apb(0, 12'h030, 0); `CHK(e, 1);
    `CHK(v, 0);
    $display("irq test done");
  endtask : t_irq
  task automatic t_presc;
    apb(1, `OFF_CTRL_TWO, 32'h07); apb(1, `OFF_COUNT, 32'h10); apb(1, `OFF_CTRL_ONE, 32'h01);
    repeat (100) @(posedge pclk);
    apb(0, `OFF_COUNT, 0); `CHK(v, 32'h10);
    apb(0, `OFF_PRESC, 0); `CHK(v != 0, 1);
    apb(1, `OFF_CTRL_ONE, 0);
    $display("prescaler test done");
  endtask : t_presc
  task automatic t_ext;
    apb(1, `OFF_CTRL_TWO, 32'h28); apb(1, `OFF_CTRL_ONE, 32'h01);
    src.pulse(3); apb(0, `OFF_COUNT, 0); `CHK(v, 32'h0D);
    apb(1, `OFF_CTRL_TWO, 32'h38); src.pulse(3);
    apb(0, `OFF_COUNT, 0); `CHK(v, 32'h0A); `CHK(pin_oe, 0);
    apb(1, `OFF_PIN_CONFIG, 32'h01); apb(1, `OFF_CTRL_ONE, 32'h80);
    repeat (2) @(posedge pclk);
    `CHK(pin_oe, 0);
    apb(1, `OFF_CTRL_ONE, 0);
    $display("external clock test done");
  endtask : t_ext
  task automatic t_pins;
    apb(1, `OFF_CTRL_TWO, 32'h08); apb(1, `OFF_PIN_CONFIG, 32'h01);
    apb(1, `OFF_COUNT, 32'h08); apb(1, `OFF_DUTY, 0);
    apb(1, `OFF_CTRL_ONE, 32'h83); watch(80); `CHK(hi, 0);
    `CHK(oe_n, 80);
    apb(1, `OFF_CTRL_ONE, 32'hC3); watch(80); `CHK(hi, 80);
    // Frame of 9 counts, 4 clocks each; duty 4 is low 16 of every 36
    apb(1, `OFF_DUTY, 32'h04); watch(72); `CHK(hi, 40);
    apb(1, `OFF_CTRL_ONE, 32'h01); apb(1, `OFF_CTRL_TWO, 0);
    apb(1, `OFF_PIN_CONFIG, 32'h02); apb(1, `OFF_TONE, 32'h80);
    watch(80); `CHK(hi > 0 && hi < 80, 1);
    `CHK(oe_n, 80);
    // Timer source: every second underflow (one per 3 counts) toggles the tone
    apb(1, `OFF_CTRL_ONE, 32'h03); apb(1, `OFF_COUNT, 32'h02); apb(1, `OFF_TONE, 32'h88);
    watch(200); `CHK(hi > 0 && hi < 200, 1);
    $display("pin test done");
  endtask : t_pins
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFF_CTRL_TWO, 0); `CHK(v, 32'h08);
    t_count(); t_irq(); t_presc(); t_ext(); t_pins();
    summarize();
  end
endmodule : down_timer_pwm_buzzer_bench

// [sim/ext_clk_src.sv]
// External count clock source and load on the shared pin
`timescale 1ns/1ps
module ext_clk_src (
  input  wire logic pclk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_in
);
  logic lvl;
  initial lvl = 1'b0;
  // Block drives when enabled, else the source level wins
  assign pin_in = pin_oe ? pin_out : lvl;
  // Slow pulses keep under the instruction clock rate
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk) lvl <= 1'b1;
      repeat (8) @(posedge pclk);
      lvl <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask : pulse
endmodule : ext_clk_src

// [sim/timer_asserts.sv]
// Bus and interrupt port checker for the down timer
`timescale 1ns/1ps
`include "tmr_defs.svh"
module timer_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pin_in,
  input wire logic        pin_out,
  input wire logic        pin_oe,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded bus phases
  wire setup   = psel && !penable;
  wire wr_done = psel && penable && pready && pwrite;
  ready_after_setup_a: assert property (setup |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready && $past(setup))
    else $error("pslverr outside access phase");
  read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  read_hold_a: assert property (!setup |=> $stable(prdata))
    else $error("read data moved outside setup");
  irq_global_off_a: assert property (wr_done && paddr == `OFF_GLOBAL_IRQ && !pwdata[0]
    |-> ##[1:2] !irq)
    else $error("irq stays with global enable off");
  irq_enable_off_a: assert property (wr_done && paddr == `OFF_IRQ_ENABLE && !pwdata[3]
    |-> ##[1:2] !irq)
    else $error("irq stays with underflow enable off");
  flag_clear_a: assert property (wr_done && paddr == `OFF_IRQ_FLAG && !pwdata[3]
    |-> ##[1:2] !irq)
    else $error("irq stays after flag clear");
  // Main scenarios
  cover property (wr_done && paddr == `OFF_COUNT);
  cover property ($rose(irq));
  cover property (pready && pslverr);
endmodule : timer_asserts
bind down_timer_pwm_buzzer timer_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .irq(irq));
